// ===== adc_avg_pkg.sv
// Register map, field positions and sequencer states of the averaging converter control.
package adc_avg_pkg;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_MODE   = 8'h04;
    localparam logic [7:0] OFS_SEQ1   = 8'h08;
    localparam logic [7:0] OFS_CHEN   = 8'h10;
    localparam logic [7:0] OFS_CHDIS  = 8'h14;
    localparam logic [7:0] OFS_CHSTAT = 8'h18;
    localparam logic [7:0] OFS_LAST   = 8'h20;
    localparam logic [7:0] OFS_LCTM   = 8'h34;
    localparam logic [7:0] OFS_LCCW   = 8'h38;
    localparam logic [7:0] OFS_EXT    = 8'h40;
    localparam logic [7:0] OFS_CWIN   = 8'h44;
    localparam logic [7:0] OFS_DIFF   = 8'h4c;
    localparam logic [7:0] OFS_CDR0   = 8'h50;
    localparam logic [7:0] OFS_CDR7   = 8'h6c;
    localparam logic [7:0] OFS_ANA    = 8'h94;
    localparam logic [7:0] OFS_WPM    = 8'he4;
    localparam logic [7:0] OFS_WPS    = 8'he8;

    localparam int CR_SWRST     = 0;
    localparam int CR_START     = 1;
    localparam int MR_TRGEN     = 0;
    localparam int MR_TSEL_LSB  = 1;
    localparam int MR_SLEEP     = 5;
    localparam int MR_USER_SEQUENCE_MODE      = 31;
    localparam int EMR_OSR_LSB  = 16;
    localparam int EMR_SEQ_REPEAT_AVG     = 20;
    localparam int EMR_TAG      = 24;
    localparam int CWR_HIGH_LSB = 16;
    localparam int ACR_TEST_LSB = 0;
    localparam int WPMR_EN      = 0;
    localparam int WPSR_SRC_LSB = 8;

    localparam logic [31:0] ACR_RST  = 32'h0008_0000;
    localparam logic [2:0]  TSEL_EXT = 3'h0;
    localparam logic [2:0]  TSEL_RTC = 3'h4;
    localparam logic [2:0]  OSR_MAX  = 3'h4;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } seq_st_t;

endpackage

// ===== adc_avg_ctrl.sv
// Sequencer, averaging, partial wakeup, DMA feed and write protection of the converter.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module adc_avg_ctrl (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Hardware trigger sources, indexed by the trigger selection.
    input  wire logic [7:0]  trig_in,
    // Analog cell.
    output logic             conv_start,
    output logic      [2:0]  conv_chan,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             analog_sleep,
    output logic      [1:0]  autotest_sel,
    // Power manager.
    input  wire logic        partial_wake_en,
    input  wire logic        system_wait,
    output logic             clk_req,
    output logic             wake_req,
    // Peripheral DMA.
    output logic             dma_req,
    output logic      [15:0] dma_data
);
    import adc_avg_pkg::*;

    typedef struct packed {
        seq_st_t          st;
        logic [2:0]       slot;
        logic [8:0]       pass;
        logic [31:0]      mode_reg;
        logic [31:0]      sequence_regs;
        logic [7:0]       enabled_channel_status;
        logic [31:0]      lc_trig_mode;
        logic [31:0]      lc_window;
        logic [31:0]      extended_mode_reg;
        logic [31:0]      compare_window_reg;
        logic [31:0]      diff_input;
        logic [31:0]      analog_control_reg;
        logic             write_protect_enable;
        logic             protect_violation_flag;
        logic [7:0]       violation_source;
        logic [7:0][19:0] acc;
        logic [7:0][8:0]  cnt;
        logic [7:0][15:0] channel_result_reg;
        logic [19:0]      last_result_reg;
        logic [31:0]      rdata;
        logic             trig_prev;
        logic             conv_start;
        logic [2:0]       conv_chan;
        logic             clk_req;
        logic             wake_req;
        logic             dma_req;
        logic [15:0]      dma_data;
    } state_t;

    state_t s_ff;
    state_t nxt_s;

    // First enabled slot at or above a starting index; bit 3 flags a hit.
    function automatic logic [3:0] find_slot(input logic [7:0] mask, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // Channel converted in a slot: the slot itself, or the slot table in user-sequence mode.
    function automatic logic [2:0] slot_chan(input logic user_sequence_mode, input logic [31:0] seq,
                                             input logic [2:0] slot);
        logic [3:0] nib;
        nib = 4'(seq >> {slot, 2'b00});
        return user_sequence_mode ? nib[2:0] : slot;
    endfunction

    // Control register command bit, shared by the start and the software reset decode.
    function automatic logic ctrl_cmd(input logic wr, input logic [7:0] a,
                                      input logic [31:0] d, input int b);
        return wr && (a == OFS_CTRL) && d[b];
    endfunction

    // Registers guarded by write protection; control and status stay reachable.
    function automatic logic is_protected(input logic [7:0] a);
        logic r;
        case (a)
            OFS_MODE, OFS_SEQ1, OFS_CHEN, OFS_CHDIS, OFS_LCTM: r = 1'b1;
            OFS_LCCW, OFS_EXT, OFS_CWIN, OFS_DIFF, OFS_ANA:     r = 1'b1;
            default:                                          r = 1'b0;
        endcase
        return r;
    endfunction

    // Word-aligned offset inside the channel data block.
    function automatic logic is_cdr(input logic [7:0] a);
        return (a >= OFS_CDR0) && (a <= OFS_CDR7) && (a[1:0] == 2'b00);
    endfunction

    // Channel number of a channel data offset.
    function automatic logic [2:0] cdr_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_CDR0;
        return d[4:2];
    endfunction

    // Inclusive window, so a result equal to a threshold still wakes the system.
    function automatic logic in_window(input logic [15:0] v, input logic [15:0] lo,
                                       input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // DMA half-word; the tag gives up the top four result bits to carry the channel.
    function automatic logic [15:0] dma_word(input logic tag, input logic [2:0] chan,
                                             input logic [15:0] v);
        return tag ? {1'b0, chan, v[11:0]} : v;
    endfunction

    logic [2:0]  tsel;
    logic [2:0]  oversample_ratio;
    logic        user_sequence_mode;
    logic        seq_repeat_avg;
    logic [8:0]  n_need;
    logic        trig_ok;
    logic        trig_edge;
    logic        go;
    logic        prot_addr;
    logic [3:0]  hit;
    logic [2:0]  ch;
    logic [19:0] sum;
    logic [8:0]  cnt_n;
    logic [15:0] avg;
    logic [15:0] low_th;
    logic [15:0] high_th;

    always_comb begin
        nxt_s = s_ff;
        tsel = s_ff.mode_reg[MR_TSEL_LSB +: 3];
        user_sequence_mode = s_ff.mode_reg[MR_USER_SEQUENCE_MODE];
        seq_repeat_avg = s_ff.extended_mode_reg[EMR_SEQ_REPEAT_AVG];
        oversample_ratio = s_ff.extended_mode_reg[EMR_OSR_LSB +: 3];
        if (oversample_ratio > OSR_MAX) begin
            oversample_ratio = OSR_MAX;
        end
        n_need = 9'h001 << {oversample_ratio, 1'b0};
        low_th = s_ff.compare_window_reg[15:0];
        high_th = s_ff.compare_window_reg[CWR_HIGH_LSB +: 16];
        hit = 4'h0;
        ch = s_ff.conv_chan;
        sum = 20'h0;
        cnt_n = 9'h000;
        avg = 16'h0000;

        nxt_s.conv_start = 1'b0;
        nxt_s.dma_req = 1'b0;
        nxt_s.wake_req = 1'b0;
        nxt_s.rdata = 32'h0;

        // Partial wakeup accepts only the pin or the real-time source.
        trig_ok = !partial_wake_en || (tsel == TSEL_EXT) || (tsel == TSEL_RTC);
        // The edge detector resets low like an idle trigger line, so reset makes no false edge.
        nxt_s.trig_prev = trig_in[tsel];
        trig_edge = trig_in[tsel] && !s_ff.trig_prev && s_ff.mode_reg[MR_TRGEN] && trig_ok;
        go = trig_edge || ctrl_cmd(reg_wr, reg_addr, reg_wdata, CR_START);
        // Leaving partial wakeup drops the clock request so it cannot stay high for good.
        if (!partial_wake_en) begin
            nxt_s.clk_req = 1'b0;
        end
        if (partial_wake_en && trig_edge) begin
            nxt_s.clk_req = 1'b1;
        end

        unique case (s_ff.st)
            ST_IDLE: begin
                if (go) begin
                    hit = find_slot(s_ff.enabled_channel_status, 4'h0);
                    if (hit[3]) begin
                        nxt_s.st = ST_BUSY;
                        nxt_s.slot = hit[2:0];
                        nxt_s.pass = 9'h000;
                        nxt_s.conv_start = 1'b1;
                        nxt_s.conv_chan = slot_chan(user_sequence_mode, s_ff.sequence_regs, hit[2:0]);
                    end
                end
            end
            ST_BUSY: begin
                if (conv_done) begin
                    // Each end of conversion counts as one sample of its channel.
                    sum = s_ff.acc[ch] + 20'(conv_data);
                    cnt_n = s_ff.cnt[ch] + 9'h001;
                    if (cnt_n >= n_need) begin
                        avg = 16'(sum >> oversample_ratio);
                        nxt_s.acc[ch] = 20'h0;
                        nxt_s.cnt[ch] = 9'h000;
                        nxt_s.channel_result_reg[ch] = avg;
                        nxt_s.last_result_reg = {1'b0, ch, avg};
                        nxt_s.dma_req = 1'b1;
                        nxt_s.dma_data = dma_word(s_ff.extended_mode_reg[EMR_TAG],
                                                  ch, avg);
                        if (partial_wake_en) begin
                            if (in_window(avg, low_th, high_th)) begin
                                nxt_s.wake_req = system_wait;
                            end else begin
                                nxt_s.clk_req = 1'b0;
                            end
                        end
                    end else begin
                        nxt_s.acc[ch] = sum;
                        nxt_s.cnt[ch] = cnt_n;
                    end
                    hit = find_slot(s_ff.enabled_channel_status, {1'b0, s_ff.slot} + 4'h1);
                    if (!hit[3] && seq_repeat_avg && !user_sequence_mode && ((s_ff.pass + 9'h001) < n_need)) begin
                        // Rerun the whole sequence without waiting for a trigger.
                        hit = find_slot(s_ff.enabled_channel_status, 4'h0);
                        nxt_s.pass = s_ff.pass + 9'h001;
                    end
                    if (hit[3]) begin
                        nxt_s.slot = hit[2:0];
                        nxt_s.conv_start = 1'b1;
                        nxt_s.conv_chan = slot_chan(user_sequence_mode, s_ff.sequence_regs, hit[2:0]);
                    end else begin
                        nxt_s.st = ST_IDLE;
                    end
                end
            end
        endcase

        // Register reads; the status read clears the flag before any new violation sets it.
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_MODE:   nxt_s.rdata = s_ff.mode_reg;
                OFS_SEQ1:   nxt_s.rdata = s_ff.sequence_regs;
                OFS_CHSTAT: nxt_s.rdata = {24'h0, s_ff.enabled_channel_status};
                OFS_LAST:   nxt_s.rdata = {12'h000, s_ff.last_result_reg};
                OFS_LCTM:   nxt_s.rdata = s_ff.lc_trig_mode;
                OFS_LCCW:   nxt_s.rdata = s_ff.lc_window;
                OFS_EXT:    nxt_s.rdata = s_ff.extended_mode_reg;
                OFS_CWIN:   nxt_s.rdata = s_ff.compare_window_reg;
                OFS_DIFF:   nxt_s.rdata = s_ff.diff_input;
                OFS_ANA:    nxt_s.rdata = s_ff.analog_control_reg;
                OFS_WPM:    nxt_s.rdata = {31'h0, s_ff.write_protect_enable};
                OFS_WPS: begin
                    nxt_s.rdata = {16'h0, s_ff.violation_source, 7'h00,
                                   s_ff.protect_violation_flag};
                    nxt_s.protect_violation_flag = 1'b0;
                end
                default: begin
                    if (is_cdr(reg_addr)) begin
                        nxt_s.rdata = {16'h0, s_ff.channel_result_reg[cdr_index(reg_addr)]};
                    end
                end
            endcase
        end

        prot_addr = is_protected(reg_addr);

        if (reg_wr) begin
            if (s_ff.write_protect_enable && prot_addr) begin
                // Refused write: nothing stored, only the violation is recorded.
                nxt_s.protect_violation_flag = 1'b1;
                nxt_s.violation_source = reg_addr;
            end else begin
                unique case (reg_addr)
                    OFS_MODE:  nxt_s.mode_reg = reg_wdata;
                    OFS_SEQ1:  nxt_s.sequence_regs = reg_wdata;
                    OFS_CHEN:  nxt_s.enabled_channel_status =
                               s_ff.enabled_channel_status | reg_wdata[7:0];
                    OFS_CHDIS: nxt_s.enabled_channel_status =
                               s_ff.enabled_channel_status & ~reg_wdata[7:0];
                    OFS_LCTM:  nxt_s.lc_trig_mode = reg_wdata;
                    OFS_LCCW:  nxt_s.lc_window = reg_wdata;
                    OFS_EXT:   nxt_s.extended_mode_reg = reg_wdata;
                    OFS_CWIN:  nxt_s.compare_window_reg = reg_wdata;
                    OFS_DIFF:  nxt_s.diff_input = reg_wdata;
                    OFS_ANA:   nxt_s.analog_control_reg = reg_wdata;
                    OFS_WPM:   nxt_s.write_protect_enable = reg_wdata[WPMR_EN];
                    default: begin
                    end
                endcase
            end
        end

        // Software reset returns every register and the sequencer to the power-up state.
        if (ctrl_cmd(reg_wr, reg_addr, reg_wdata, CR_SWRST)) begin
            nxt_s = '0;
            nxt_s.analog_control_reg = ACR_RST;
        end
    end

    // Hardware reset loads the same image as a software reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff <= '0;
            s_ff.analog_control_reg <= ACR_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reg_rdata    = s_ff.rdata;
    assign conv_start   = s_ff.conv_start;
    assign conv_chan    = s_ff.conv_chan;
    assign analog_sleep = s_ff.mode_reg[MR_SLEEP];
    assign autotest_sel = s_ff.analog_control_reg[ACR_TEST_LSB +: 2];
    assign clk_req      = s_ff.clk_req;
    assign wake_req     = s_ff.wake_req;
    assign dma_req      = s_ff.dma_req;
    assign dma_data     = s_ff.dma_data;

endmodule

// ===== adc_cell_model.sv
// Behavioural analog cell that answers each conversion start after a short or long delay.
`timescale 1ns/1ps
module adc_cell_model (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Conversion link.
    input  wire logic        conv_start,
    input  wire logic [2:0]  conv_chan,
    output logic             conv_done,
    output logic      [11:0] conv_data,
    // Stimulus controls.
    input  wire logic [11:0] level,
    input  wire logic        slow
);
    logic [3:0]  cnt;
    logic [2:0]  ch;
    logic        busy;
    logic [11:0] last;
    // Outside the done cycle the bus carries the inverse, so a stale sample never matches.
    assign conv_data = conv_done ? last : ~last;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {cnt, ch, busy, conv_done, last} <= '0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                busy <= 1'b1;
                ch   <= conv_chan;
                cnt  <= slow ? 4'h6 : 4'h1;
            end else if (busy && cnt == 4'h0) begin
                busy      <= 1'b0;
                conv_done <= 1'b1;
                last      <= level + {5'h0, ch, 4'h0};
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// ===== adc_avg_ctrl_properties.sv
// Port-level checks of the converter control, bound to its top module.
`timescale 1ns/1ps
module adc_avg_ctrl_properties (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // Register port.
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Triggers, conversion, power and DMA.
    input wire logic [7:0]  trig_in,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic        analog_sleep,
    input wire logic        partial_wake_en,
    input wire logic        system_wait,
    input wire logic        clk_req,
    input wire logic        wake_req,
    input wire logic        dma_req
);
    import adc_avg_pkg::*;
    logic [7:0] trig_q;
    logic       prot_q;
    wire        trig_rise = |(trig_in & ~trig_q);
    wire        sleep_bit = reg_wdata[MR_SLEEP];
    wire        prot_hit  = reg_addr inside {OFS_MODE, OFS_SEQ1, OFS_CHEN, OFS_CHDIS,
        OFS_LCTM, OFS_LCCW, OFS_EXT, OFS_CWIN, OFS_DIFF, OFS_ANA};
    wire        bad_wr    = reg_wr && prot_hit && prot_q;
    wire        wps_rd    = reg_rd && reg_addr == OFS_WPS;
    // A soft reset also clears protection, so the shadow follows it.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_q <= 8'h00;
            prot_q <= 1'b0;
        end else begin
            trig_q <= trig_in;
            if (reg_wr && reg_addr == OFS_WPM) begin
                prot_q <= reg_wdata[WPMR_EN];
            end else if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CR_SWRST]) begin
                prot_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_dma_cause: assert property (dma_req |-> $past(conv_done))
        else $error("dma request without a completed conversion");
    a_dma_single: assert property (dma_req |=> !dma_req)
        else $error("dma request longer than one cycle");
    a_clk_on_trig: assert property ($rose(clk_req) |-> $past(partial_wake_en)
        && ($past(trig_rise) || $past(trig_rise, 2))) else $error("clock request without trigger");
    a_wake_cause: assert property (wake_req |-> $past(system_wait) && $past(conv_done))
        else $error("wake request without wait and conversion");
    a_wake_keeps_clk: assert property (wake_req |-> clk_req ##1 !wake_req)
        else $error("wake request without held clock request");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    a_sleep_write: assert property (reg_wr && reg_addr == OFS_MODE && !prot_q |->
        ##2 analog_sleep == $past(sleep_bit, 2)) else $error("sleep output not following mode");
    a_prot_hold: assert property (bad_wr |=> $stable(analog_sleep) [*2])
        else $error("refused write changed the mode");
    a_viol_flag: assert property (bad_wr ##1 wps_rd |=> reg_rdata[0]
        && reg_rdata[15:8] == $past(reg_addr, 2)) else $error("violation not recorded");
    a_rd_clear: assert property (wps_rd ##1 wps_rd |=> !reg_rdata[0])
        else $error("violation flag not cleared by read");
    c_dma: cover property (dma_req);
    c_wake: cover property (wake_req);
    c_violation: cover property (bad_wr);
endmodule
bind adc_avg_ctrl adc_avg_ctrl_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_in(trig_in), .conv_start(conv_start), .conv_done(conv_done),
    .analog_sleep(analog_sleep), .partial_wake_en(partial_wake_en),
    .system_wait(system_wait), .clk_req(clk_req), .wake_req(wake_req), .dma_req(dma_req));

// ===== tb.sv
// Self-checking bench of the converter control with an analog cell model.
`timescale 1ns/1ps
module tb;
    import adc_avg_pkg::*;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, partial_wake_en, system_wait, slow;
    logic        conv_start, conv_done, analog_sleep, clk_req, wake_req, dma_req;
    logic [7:0]  reg_addr, trig_in;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  conv_chan;
    logic [11:0] conv_data, level;
    logic [1:0]  autotest_sel;
    logic [15:0] dma_data;
    logic [15:0] dq[$];
    logic [31:0] seed = 32'h0000_c320;
    int          errors = 0, compares = 0, cyc = 0, wakes = 0;
    logic [7:0]  prot_ofs[10] = '{OFS_MODE, OFS_SEQ1, OFS_CHEN, OFS_CHDIS, OFS_LCTM, OFS_LCCW,
                                  OFS_EXT, OFS_CWIN, OFS_DIFF, OFS_ANA};
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    adc_avg_ctrl u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trig_in(trig_in), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_done(conv_done), .conv_data(conv_data), .analog_sleep(analog_sleep),
        .autotest_sel(autotest_sel), .partial_wake_en(partial_wake_en),
        .system_wait(system_wait), .clk_req(clk_req), .wake_req(wake_req),
        .dma_req(dma_req), .dma_data(dma_data));
    adc_cell_model u_cell (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
        .level(level), .slow(slow));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] avg(logic [11:0] v, int k);
        return 16'(v) << k;
    endfunction
    task automatic print_verdict();
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string n, logic [31:0] m = '1);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check(n, reg_rdata & m, e);
    endtask
    // Each pulse stays high for three cycles, well past the minimum width.
    task automatic trig(int n, int src = 0);
        repeat (n) begin
            trig_in[src] <= 1'b1;
            repeat (3) @(posedge ref_clk);
            trig_in[src] <= 1'b0;
            repeat (40 + (rnd() & 15)) @(posedge ref_clk);
        end
    endtask
    task automatic wait_dma(int n);
        for (int i = 0; i < 6000 && dq.size() < n; i++) @(posedge ref_clk);
        #1;
        check("dma count", dq.size(), n);
    endtask
    task automatic chk_dma(logic [15:0] e);
        check("dma data", {16'h0, dq.pop_front()}, {16'h0, e});
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (dma_req === 1'b1) dq.push_back(dma_data);
        if (wake_req === 1'b1) wakes <= wakes + 1;
        if (cyc == 60000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, partial_wake_en, system_wait, slow} = 6'b100000;
        {reg_addr, trig_in, reg_wdata, level} = '0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_ANA, ACR_RST, "analog control reset");
        rd(8'h0c, 32'h0, "unmapped");
        wr(OFS_ANA, 32'h2);
        rd(OFS_ANA, 32'h2, "analog control");
        check("autotest", autotest_sel, 32'h2);
        wr(OFS_CHEN, 32'h3);
        rd(OFS_CHSTAT, 32'h3, "channel status");
        wr(OFS_MODE, 32'h1);
        for (int k = 0; k < 5; k++) begin
            level = 12'(rnd() & 32'h7ff);
            slow  = rnd() & 1;
            wr(OFS_EXT, 32'h0010_0000 | 32'(k << EMR_OSR_LSB) | 32'(k == 0) << EMR_TAG);
            trig(1);
            wait_dma(2);
            chk_dma(k == 0 ? {4'h0, level} : avg(level, k));
            chk_dma(k == 0 ? {4'h1, level + 12'h10} : avg(level + 12'h10, k));
        end
        wr(OFS_EXT, 32'h0001_0000);
        trig(3);
        wait_dma(0);
        trig(1);
        wait_dma(2);
        chk_dma(avg(level, 1));
        chk_dma(avg(level + 12'h10, 1));
        wr(OFS_CHEN, 32'hff);
        wr(OFS_SEQ1, 32'h1111_0000);
        wr(OFS_EXT, 32'h0011_0000);
        wr(OFS_MODE, 32'h8000_0001);
        trig(1);
        wait_dma(2);
        chk_dma(avg(level, 1));
        chk_dma(avg(level + 12'h10, 1));
        rd(OFS_LAST, {12'h0, 4'h1, avg(level + 12'h10, 1)}, "last result");
        rd(OFS_CDR0, {16'h0, avg(level, 1)}, "channel 0 result");
        wr(OFS_CHDIS, 32'hfe);
        wr(OFS_EXT, 32'h0);
        wr(OFS_CWIN, {4'h0, level, 4'h0, level});
        wr(OFS_MODE, 32'h21);
        // Registers stay untouched from here until partial wakeup is left again.
        partial_wake_en <= 1'b1;
        system_wait     <= 1'b1;
        trig(1);
        wait_dma(1);
        chk_dma({4'h0, level});
        check("wake count", wakes, 32'h1);
        check("clock request", clk_req, 32'h1);
        level = level + 12'h1;
        trig(1);
        wait_dma(1);
        chk_dma({4'h0, level});
        check("wake count", wakes, 32'h1);
        check("clock request", clk_req, 32'h0);
        partial_wake_en <= 1'b0;
        system_wait     <= 1'b0;
        wr(OFS_MODE, 32'h23);
        partial_wake_en <= 1'b1;
        trig(1, 1);
        wait_dma(0);
        check("clock request", clk_req, 32'h0);
        partial_wake_en <= 1'b0;
        wr(OFS_WPM, 32'h1);
        wr(OFS_MODE, 32'h0);
        rd(OFS_WPS, {16'h0, OFS_MODE, 8'h01}, "violation");
        rd(OFS_WPS, 32'h0, "flag clear", 32'h1);
        rd(OFS_MODE, 32'h23, "mode kept");
        foreach (prot_ofs[i]) begin
            wr(prot_ofs[i], rnd());
            rd(OFS_WPS, {16'h0, prot_ofs[i], 8'h01}, "violation source");
        end
        rd(OFS_CHSTAT, 32'h1, "channels kept");
        rd(OFS_ANA, 32'h2, "analog control kept");
        wr(OFS_CTRL, 32'h1);
        rd(OFS_MODE, 32'h0, "mode after soft reset");
        print_verdict();
    end
endmodule
